/* rtl/sbrt_pkg.sv */
// Package: register map, field positions and timing counts of the timer
package sbrt_pkg;
	// Byte addresses on the APB slave
	localparam logic [7:0] CTRL_OFFSET = 8'hc8;
	localparam logic [7:0] CLKSEL_OFFSET = 8'hcc;
	localparam logic [7:0] COUNT_OFFSET = 8'hd0;
	localparam logic [7:0] RELOAD_OFFSET = 8'hd4;
	localparam logic [7:0] IE_OFFSET = 8'hd8;
	// Control register fields
	localparam int CTRL_HIGH_FLAG_BIT = 7;
	localparam int CTRL_LOW_FLAG_BIT = 6;
	localparam int CTRL_LOW_IE_BIT = 5;
	localparam int CTRL_CAPTURE_BIT = 4;
	localparam int CTRL_SPLIT_BIT = 3;
	localparam int CTRL_RUN_BIT = 2;
	localparam int CTRL_CSS_BIT = 1;
	localparam int CTRL_XCLK_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Clock select register fields
	localparam int CLKSEL_LOW_BIT = 0;
	localparam int CLKSEL_HIGH_BIT = 1;
	localparam logic [1:0] CLKSEL_RESET = 2'h0;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	// Prescaler ratios
	localparam int SYS_DIV = 12;
	localparam int EXT_DIV = 8;
endpackage

/* rtl/sbrt_tick_if.sv */
// Interface: count enables from the prescaler to the counters
`timescale 1ns/1ps
interface sbrt_tick_if;
	logic sys_tick;
	logic div12_tick;
	logic ext8_tick;
	modport src (output sys_tick, output div12_tick, output ext8_tick);
	modport dst (input sys_tick, input div12_tick, input ext8_tick);
endinterface

/* rtl/sbrt_prescaler.sv */
// Prescaler: divide by 12 and synchronised external clock divide by 8
`timescale 1ns/1ps
module sbrt_prescaler
	import sbrt_pkg::*;
#(
	parameter int SYS_DIV_P = SYS_DIV,
	parameter int EXT_DIV_P = EXT_DIV
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ext_clk_i,
	sbrt_tick_if.src tick
);
	import sbrt_pkg::*;

	logic [3:0] div12_reg, div12_next;
	logic sync1_reg, sync2_reg, sync3_reg;
	logic [2:0] ext_cnt_reg, ext_cnt_next;
	logic ext_edge;

	////////////////////////////////////////////////////////////////
	always_comb begin
		ext_edge = sync2_reg & ~sync3_reg;
		div12_next = (div12_reg == 4'(SYS_DIV_P - 1)) ? 4'h0 :
			4'(div12_reg + 4'h1);
		ext_cnt_next = ext_cnt_reg;
		if (ext_edge) begin
			ext_cnt_next = 3'(ext_cnt_reg + 3'h1);
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div12_reg <= 4'h0;
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			ext_cnt_reg <= 3'h0;
		end else begin
			div12_reg <= div12_next;
			// Slow external clock is sampled, never used as a clock
			sync1_reg <= ext_clk_i;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			ext_cnt_reg <= ext_cnt_next;
		end
	end

	assign tick.sys_tick = 1'b1;
	assign tick.div12_tick = (div12_reg == 4'(SYS_DIV_P - 1));
	// One enable per eighth rising edge of the external clock
	assign tick.ext8_tick = ext_edge &&
		(ext_cnt_reg == 3'(EXT_DIV_P - 1));
endmodule

/* rtl/sbrt_capture_sel.sv */
// Capture trigger selection and edge detection
`timescale 1ns/1ps
module sbrt_capture_sel (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic source_i,
	input wire logic sof_pulse_i,
	input wire logic lfo_i,
	output logic event_o
);
	logic lfo_d_reg, lfo_d_next;

	always_comb begin
		lfo_d_next = lfo_i;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lfo_d_reg <= 1'b0;
		end else begin
			lfo_d_reg <= lfo_d_next;
		end
	end

	// 0 picks the frame event, 1 the oscillator falling edge
	assign event_o = source_i ? (lfo_d_reg & ~lfo_i) : sof_pulse_i;
endmodule

/* rtl/sbrt_top.sv */
// Split byte reload timer with APB register access
`timescale 1ns/1ps

// Behaviour
// - Split mode: two independent 8-bit counters
// - Each byte reloads from its own register
// - Split mode: run control gates high byte only
// - Per-byte select: system clock or shared choice
// - Both bytes share one external clock select
// - High byte rollover sets high flag
// - Low byte rollover sets low flag
// - Interrupt on every high byte overflow
// - Low enable adds low byte overflow interrupt
// - Flags cleared only by software writing zero
// - External select gives external clock over 8
module sbrt_top (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic ext_clk_i,
	input wire logic sof_pulse_i,
	input wire logic lfo_i,
	output logic irq_o
);
	import sbrt_pkg::*;

	sbrt_tick_if tick ();

	logic [7:0] ctrl_reg, ctrl_next;
	logic [1:0] clksel_reg, clksel_next;
	logic [7:0] cnt_hi_reg, cnt_hi_next;
	logic [7:0] cnt_lo_reg, cnt_lo_next;
	logic [7:0] rld_hi_reg, rld_hi_next;
	logic [7:0] rld_lo_reg, rld_lo_next;
	logic timer_ie_reg, timer_ie_next;
	logic [31:0] rdata_reg, rdata_next;
	logic slverr_reg, slverr_next;
	logic wr_en, rd_en, hit;
	logic ext_sel, split_on, capture_on, run_on;
	logic en_hi, en_lo, en_16;
	logic ovf_hi, ovf_lo;
	logic cap_event;
	logic [15:0] cnt_inc;
	logic [7:0] wbyte;
	logic sel_ctrl;
	logic sel_clksel;
	logic sel_count;
	logic sel_reload;
	logic sel_ie;
	logic irq_reg, irq_next;

	////////////////////////////////////////////////////////////////
	sbrt_prescaler u_prescaler (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ext_clk_i(ext_clk_i),
		.tick(tick)
	);

	sbrt_capture_sel u_capture (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.source_i(ctrl_reg[CTRL_CSS_BIT]),
		.sof_pulse_i(sof_pulse_i),
		.lfo_i(lfo_i),
		.event_o(cap_event)
	);

	////////////////////////////////////////////////////////////////
	assign wr_en = psel_i & penable_i & pwrite_i;
	// Read data are latched in the setup cycle and stand through access
	assign rd_en = psel_i & ~penable_i & ~pwrite_i;
	assign wbyte = pwdata_i[7:0];
	assign split_on = ctrl_reg[CTRL_SPLIT_BIT];
	assign capture_on = ctrl_reg[CTRL_CAPTURE_BIT];
	assign run_on = ctrl_reg[CTRL_RUN_BIT];
	// Clock choice per byte: 1 is the system clock
	always_comb begin
		// One shared divided source for both bytes
		if (ctrl_reg[CTRL_XCLK_BIT]) begin
			ext_sel = tick.ext8_tick;
		end else begin
			ext_sel = tick.div12_tick;
		end
		en_hi = ext_sel;
		if (clksel_reg[CLKSEL_HIGH_BIT]) begin
			en_hi = tick.sys_tick;
		end
		en_lo = ext_sel;
		if (clksel_reg[CLKSEL_LOW_BIT]) begin
			en_lo = tick.sys_tick;
		end
	end
	assign en_16 = en_lo & run_on & ~capture_on;
	assign cnt_inc = 16'({cnt_hi_reg, cnt_lo_reg} + 16'h0001);

	always_comb begin
		cnt_hi_next = cnt_hi_reg;
		cnt_lo_next = cnt_lo_reg;
		ovf_hi = 1'b0;
		ovf_lo = 1'b0;
		if (split_on && !capture_on) begin
			// Low byte runs regardless of run control
			if (en_lo) begin
				if (cnt_lo_reg == 8'hff) begin
					ovf_lo = 1'b1;
					cnt_lo_next = rld_lo_reg;
				end else begin
					cnt_lo_next = 8'(cnt_lo_reg + 8'h01);
				end
			end
			if (en_hi && run_on) begin
				if (cnt_hi_reg == 8'hff) begin
					ovf_hi = 1'b1;
					cnt_hi_next = rld_hi_reg;
				end else begin
					cnt_hi_next = 8'(cnt_hi_reg + 8'h01);
				end
			end
		end else if (en_16) begin
			// 16-bit auto-reload; low byte flag still sets on its wrap
			ovf_lo = (cnt_lo_reg == 8'hff);
			if ({cnt_hi_reg, cnt_lo_reg} == 16'hffff) begin
				ovf_hi = 1'b1;
				cnt_hi_next = rld_hi_reg;
				cnt_lo_next = rld_lo_reg;
			end else begin
				cnt_hi_next = cnt_inc[15:8];
				cnt_lo_next = cnt_inc[7:0];
			end
		end else if (capture_on && run_on && en_lo) begin
			// Capture mode: free 16-bit count, wrap without reload
			ovf_lo = (cnt_lo_reg == 8'hff);
			ovf_hi = ({cnt_hi_reg, cnt_lo_reg} == 16'hffff);
			cnt_hi_next = cnt_inc[15:8];
			cnt_lo_next = cnt_inc[7:0];
		end
		if (wr_en && sel_count) begin
			cnt_lo_next = wbyte;
			cnt_hi_next = pwdata_i[15:8];
		end
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		ctrl_next = ctrl_reg;
		clksel_next = clksel_reg;
		rld_hi_next = rld_hi_reg;
		rld_lo_next = rld_lo_reg;
		timer_ie_next = timer_ie_reg;
		if (wr_en) begin
			if (sel_ctrl) begin
				ctrl_next = wbyte;
			end else if (sel_clksel) begin
				clksel_next = pwdata_i[1:0];
			end else if (sel_reload) begin
				rld_lo_next = wbyte;
				rld_hi_next = pwdata_i[15:8];
			end else if (sel_ie) begin
				timer_ie_next = pwdata_i[0];
			end
		end
		// Hardware only sets; a set in the clearing cycle wins
		if (ovf_hi) begin
			ctrl_next[CTRL_HIGH_FLAG_BIT] = 1'b1;
		end
		if (ovf_lo) begin
			ctrl_next[CTRL_LOW_FLAG_BIT] = 1'b1;
		end
		// Capture beats a reload write landing the same cycle
		if (capture_on && cap_event) begin
			rld_hi_next = cnt_hi_reg;
			rld_lo_next = cnt_lo_reg;
			// The high flag carries the capture request to the interrupt
			ctrl_next[CTRL_HIGH_FLAG_BIT] = 1'b1;
		end
	end

	// Built from next values so the request moves with the flags
	always_comb begin
		irq_next = 1'b0;
		if (timer_ie_next) begin
			if (ctrl_next[CTRL_HIGH_FLAG_BIT]) begin
				irq_next = 1'b1;
			end
			// Low byte joins only when its own enable is set
			if (ctrl_next[CTRL_LOW_IE_BIT] &&
				ctrl_next[CTRL_LOW_FLAG_BIT]) begin
				irq_next = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Address decode shared by the write and read paths
	always_comb begin
		sel_ctrl = 1'b0;
		sel_clksel = 1'b0;
		sel_count = 1'b0;
		sel_reload = 1'b0;
		sel_ie = 1'b0;
		// Unmapped addresses leave every select low
		if (paddr_i == CTRL_OFFSET) begin
			sel_ctrl = 1'b1;
		end else if (paddr_i == CLKSEL_OFFSET) begin
			sel_clksel = 1'b1;
		end else if (paddr_i == COUNT_OFFSET) begin
			sel_count = 1'b1;
		end else if (paddr_i == RELOAD_OFFSET) begin
			sel_reload = 1'b1;
		end else if (paddr_i == IE_OFFSET) begin
			sel_ie = 1'b1;
		end
	end

	always_comb begin
		hit = 1'b1;
		rdata_next = 32'h0000_0000;
		if (sel_ctrl) begin
			rdata_next = {24'h00_0000, ctrl_reg};
		end else if (sel_clksel) begin
			rdata_next = {30'h0000_0000, clksel_reg};
		end else if (sel_count) begin
			rdata_next = {16'h0000, cnt_hi_reg, cnt_lo_reg};
		end else if (sel_reload) begin
			rdata_next = {16'h0000, rld_hi_reg, rld_lo_reg};
		end else if (sel_ie) begin
			rdata_next = {31'h0000_0000, timer_ie_reg};
		end else begin
			// Unmapped: reads zero and flags an error in access
			hit = 1'b0;
		end
		if (!rd_en) begin
			rdata_next = rdata_reg;
		end
		slverr_next = psel_i & ~penable_i & ~hit;
	end

	////////////////////////////////////////////////////////////////
	// Count bytes: written by software or advanced by ticks
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_hi_reg <= COUNT_RESET[15:8];
			cnt_lo_reg <= COUNT_RESET[7:0];
		end else begin
			cnt_hi_reg <= cnt_hi_next;
			cnt_lo_reg <= cnt_lo_next;
		end
	end

	// Software state plus the hardware-set flags
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RESET;
			clksel_reg <= CLKSEL_RESET;
			rld_hi_reg <= RELOAD_RESET[15:8];
			rld_lo_reg <= RELOAD_RESET[7:0];
			timer_ie_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			clksel_reg <= clksel_next;
			rld_hi_reg <= rld_hi_next;
			rld_lo_reg <= rld_lo_next;
			timer_ie_reg <= timer_ie_next;
		end
	end

	// Registered so the pin never glitches while flags settle
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// Read latch and error flag of the bus slave
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			slverr_reg <= slverr_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Zero wait states; read data is registered in the setup cycle
	assign pready_o = 1'b1;
	assign prdata_o = rdata_reg;
	assign pslverr_o = slverr_reg & psel_i & penable_i;

	// Level request while any enabled flag stands
	assign irq_o = irq_reg;
endmodule

/* sim/sbrt_top_chk.sv */
// Checker: port-level properties of the split byte reload timer
`timescale 1ns/1ps
module sbrt_top_chk
	import sbrt_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic ext_clk_i,
	input wire logic sof_pulse_i,
	input wire logic lfo_i,
	input wire logic irq_o
);
	// Shadow of software-only bits: ie, clock selects, control 5..0
	logic [8:0] sh_reg;
	logic [8:0] sh_next;
	logic acc;
	logic wr;
	logic rd;
	logic hit;
	assign acc = psel_i & penable_i;
	assign wr = acc & pwrite_i;
	assign rd = acc & ~pwrite_i;
	assign hit = paddr_i inside {CTRL_OFFSET, CLKSEL_OFFSET, COUNT_OFFSET,
		RELOAD_OFFSET, IE_OFFSET};
	always_comb begin
		sh_next = sh_reg;
		if (wr && paddr_i == CTRL_OFFSET) sh_next[5:0] = pwdata_i[5:0];
		if (wr && paddr_i == CLKSEL_OFFSET) sh_next[7:6] = pwdata_i[1:0];
		if (wr && paddr_i == IE_OFFSET) sh_next[8] = pwdata_i[0];
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) sh_reg <= '0;
		else sh_reg <= sh_next;
	end
	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	property p_ready; acc |-> pready_o; endproperty
	a_ready: assert property (p_ready)
		else $error("pready low in access phase");
	property p_err; acc && !hit |-> pslverr_o; endproperty
	a_err: assert property (p_err)
		else $error("no error on unmapped access");
	property p_ok; acc && hit |-> !pslverr_o; endproperty
	a_ok: assert property (p_ok)
		else $error("error on mapped access");
	property p_hold;
		$changed(prdata_o) |-> $past(psel_i) && !$past(penable_i) &&
			!$past(pwrite_i);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved outside a read setup");
	property p_fall; $fell(irq_o) |-> $past(wr); endproperty
	a_fall: assert property (p_fall)
		else $error("irq dropped without a write");
	property p_ie; !sh_reg[8] |-> !irq_o; endproperty
	a_ie: assert property (p_ie)
		else $error("irq while disabled");
	property p_ctrl;
		rd && paddr_i == CTRL_OFFSET |-> prdata_o[5:0] == sh_reg[5:0];
	endproperty
	a_ctrl: assert property (p_ctrl)
		else $error("control bits read back wrong");
	property p_clk;
		rd && paddr_i == CLKSEL_OFFSET |-> prdata_o[1:0] == sh_reg[7:6];
	endproperty
	a_clk: assert property (p_clk)
		else $error("clock selects read back wrong");
endmodule
bind sbrt_top sbrt_top_chk u_chk (.sys_clk_i, .rst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
	.ext_clk_i, .sof_pulse_i, .lfo_i, .irq_o);

/* sim/sbrt_top_bench.sv */
// Testbench: register-level tests of the split byte reload timer
`timescale 1ns/1ps
module sbrt_top_bench;
	import sbrt_pkg::*;
	logic sys_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0;
	logic pwrite_i = 0, ext_clk_i = 0, sof_pulse_i = 0, lfo_i = 1;
	logic ext_run = 0, pready_o, pslverr_o, irq_o, er;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	// Each entry: control value written, then the irq level expected
	logic [8:0] irq_tab [5] = '{9'h080, 9'h0c1, 9'h101, 9'h040, 9'h141};
	int bad_count = 0, num_checks = 0, ec = 0;
	sbrt_top dut (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ext_clk_i,
		.sof_pulse_i, .lfo_i, .irq_o);
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	// External clock of ten system periods, well under half the rate
	always @(posedge sys_clk_i) begin
		if (ext_run) begin
			ec <= (ec == 4) ? 0 : ec + 1;
			if (ec == 4) ext_clk_i <= ~ext_clk_i;
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		// Request stands until the edge at which pready is seen high
		@(posedge sys_clk_i);
		while (pready_o !== 1'b1) @(posedge sys_clk_i);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
		input string n);
		xfer(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge sys_clk_i);
		bad_count++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rdchk(CTRL_OFFSET, 32'h0, "ctrl reset");
		rdchk(CLKSEL_OFFSET, 32'h0, "clksel reset");
		rdchk(8'hc4, 32'h0, "unmapped read");
		chk("unmapped err", er, 1'b1);
		// Split: low byte on system clock, high byte stopped
		xfer(1'b1, RELOAD_OFFSET, 32'hf8f0);
		xfer(1'b1, COUNT_OFFSET, 32'h12f0);
		xfer(1'b1, CLKSEL_OFFSET, 32'h1);
		xfer(1'b1, CTRL_OFFSET, 32'h08);
		repeat (40) @(posedge sys_clk_i);
		xfer(1'b0, COUNT_OFFSET, 32'h0);
		chk("high held", rd[15:8], 8'h12);
		chk("low in span", rd[7:0] >= 8'hf0, 1'b1);
		rdchk(CTRL_OFFSET, 32'h48, "low flag only");
		xfer(1'b1, CLKSEL_OFFSET, 32'h3);
		// High byte starts near its top so it wraps inside the span
		xfer(1'b1, COUNT_OFFSET, 32'hf8f0);
		xfer(1'b1, CTRL_OFFSET, 32'h0c);
		repeat (40) @(posedge sys_clk_i);
		xfer(1'b0, COUNT_OFFSET, 32'h0);
		chk("high in span", rd[15:8] >= 8'hf8, 1'b1);
		rdchk(CTRL_OFFSET, 32'hcc, "both flags");
		// Stop both bytes, then walk the interrupt combinations
		xfer(1'b1, CTRL_OFFSET, 32'h0);
		xfer(1'b1, CTRL_OFFSET, 32'h0);
		xfer(1'b1, IE_OFFSET, 32'h1);
		foreach (irq_tab[i]) begin
			xfer(1'b1, CTRL_OFFSET, {24'h0, irq_tab[i][8:1]});
			@(negedge sys_clk_i);
			chk("irq", irq_o, irq_tab[i][0]);
		end
		xfer(1'b1, IE_OFFSET, 32'h0);
		@(negedge sys_clk_i);
		chk("irq masked", irq_o, 1'b0);
		// Both bytes from the divide-by-12 tick
		xfer(1'b1, CTRL_OFFSET, 32'h0);
		xfer(1'b1, COUNT_OFFSET, 32'h0);
		xfer(1'b1, RELOAD_OFFSET, 32'h0);
		xfer(1'b1, CLKSEL_OFFSET, 32'h0);
		xfer(1'b1, CTRL_OFFSET, 32'h0c);
		repeat (240) @(posedge sys_clk_i);
		xfer(1'b0, COUNT_OFFSET, 32'h0);
		chk("div12 low", rd[7:0] inside {[8'h13:8'h15]}, 1'b1);
		chk("div12 high", rd[15:8] inside {[8'h13:8'h15]}, 1'b1);
		// High byte from the external clock over 8, low on system clock
		ext_run <= 1'b1;
		xfer(1'b1, CTRL_OFFSET, 32'h0);
		xfer(1'b1, COUNT_OFFSET, 32'h0);
		xfer(1'b1, CLKSEL_OFFSET, 32'h1);
		xfer(1'b1, CTRL_OFFSET, 32'h0d);
		repeat (400) @(posedge sys_clk_i);
		xfer(1'b0, COUNT_OFFSET, 32'h0);
		chk("ext high", rd[15:8] inside {[8'h04:8'h06]}, 1'b1);
		// Capture with the count stopped, each source in turn
		xfer(1'b1, CTRL_OFFSET, 32'h0);
		xfer(1'b1, COUNT_OFFSET, 32'h1234);
		xfer(1'b1, RELOAD_OFFSET, 32'h0);
		xfer(1'b1, CTRL_OFFSET, 32'h10);
		lfo_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rdchk(RELOAD_OFFSET, 32'h0, "lfo ignored");
		sof_pulse_i <= 1'b1;
		@(posedge sys_clk_i);
		sof_pulse_i <= 1'b0;
		lfo_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		rdchk(RELOAD_OFFSET, 32'h1234, "sof capture");
		rdchk(CTRL_OFFSET, 32'h90, "sof flag");
		xfer(1'b1, CTRL_OFFSET, 32'h12);
		xfer(1'b1, COUNT_OFFSET, 32'h5678);
		sof_pulse_i <= 1'b1;
		@(posedge sys_clk_i);
		sof_pulse_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rdchk(RELOAD_OFFSET, 32'h1234, "sof ignored");
		lfo_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rdchk(RELOAD_OFFSET, 32'h5678, "lfo capture");
		rdchk(CTRL_OFFSET, 32'h92, "lfo flag");
		xfer(1'b1, IE_OFFSET, 32'h1);
		@(negedge sys_clk_i);
		chk("capture irq", irq_o, 1'b1);
		summarize();
	end
endmodule
